// >>> pkg/gdpc_pkg.sv
// Constants for the gate driver protection configuration block.
// Assumes a 100 MHz APB clock and asynchronous comparator inputs.
// Summary of operation
// - Config at ACh, all zero after reset
// - Slew code 2 is 125, 3 is 200
// - Level bit clear 34 V, set 22 V
// - Overvoltage protection only while bit set
// - Thermal warning reported only while bit set
// - Overcurrent code 0 latches, 1 retries 500 ms
// - Filter codes select 0.2/0.6/1.2/1.6 us
// - Threshold bit clear 16 A, set 24 A
// - Fixed gain used only without adaptive gain
`default_nettype none
package gdpc_pkg;
   localparam int          ADDR_W     = 8;
   localparam int          CLK_MHZ    = 100;
   localparam logic [7:0]  OFS_CFG    = 8'hac;
   localparam logic [7:0]  OFS_STAT   = 8'hb0;
   localparam logic [7:0]  OFS_MASK   = 8'hb4;
   localparam logic [7:0]  OFS_CTRL   = 8'hb8;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK  = 32'h8c0d_3703;
   localparam int          PARITY_BIT = 31;
   localparam int          SLEW_LSB   = 26;
   localparam int          OVSEL_BIT  = 19;
   localparam int          OVEN_BIT   = 18;
   localparam int          OTW_BIT    = 16;
   localparam int          FILT_LSB   = 12;
   localparam int          OCTHR_BIT  = 10;
   localparam int          RESP_LSB   = 8;
   localparam int          GAIN_LSB   = 0;
   localparam logic [1:0]  SLEW_125   = 2'h2;
   localparam logic [1:0]  SLEW_200   = 2'h3;
   localparam logic [1:0]  RESP_LATCH = 2'h0;
   localparam logic [1:0]  RESP_RETRY = 2'h1;
   localparam int          ST_OV      = 0;
   localparam int          ST_OTW     = 1;
   localparam int          ST_OCF     = 2;
   localparam int          ST_RETRY   = 3;
   localparam int          ST_W       = 4;
   localparam int          CTL_ADAPT  = 0;
   localparam int          CTL_OCCLR  = 1;
   localparam int          RETRY_MS   = 500;
   localparam int          RETRY_CYC  = RETRY_MS * 1000 * CLK_MHZ;
   localparam int          FILT_NS [4] = '{200, 600, 1200, 1600};
   typedef enum logic [1:0]
   {
      GDPC_OC_IDLE    = 2'b00,
      GDPC_OC_FILTER  = 2'b01,
      GDPC_OC_LATCHED = 2'b10,
      GDPC_OC_RETRY   = 2'b11
   } gdpc_oc_state_t;
   // Least time, so round up to whole cycles
   function automatic logic [7:0] filt_cyc(input logic [1:0] code);
      filt_cyc = 8'((FILT_NS[code] * CLK_MHZ + 999) / 1000);
   endfunction
endpackage
`default_nettype wire

// >>> rtl/gdpc_top.sv
// Gate driver protection configuration register and its protection logic.
// Assumes an APB master on pclk; comparator inputs are asynchronous.
`default_nettype none
module gdpc_top #(
   parameter int RETRY_CYCLES = gdpc_pkg::RETRY_CYC
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [gdpc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output var  logic [31:0]               prdata,
   output var  logic                      pready,
   output var  logic                      pslverr,
   input  wire logic                      overvoltage_raw,
   input  wire logic                      thermal_warning_raw,
   input  wire logic                      overcurrent_raw,
   output var  logic                      irq,
   output var  logic [1:0]                slew_rate_sel,
   output var  logic                      slew_rate_valid,
   output var  logic                      supply_overvoltage_level_sel,
   output var  logic                      supply_overvoltage_fault,
   output var  logic                      thermal_warning_out,
   output var  logic                      overcurrent_threshold_sel,
   output var  logic                      overcurrent_fault,
   output var  logic [1:0]                current_amp_gain_sel,
   output var  logic                      current_amp_gain_fixed
);
   import gdpc_pkg::*;

   localparam int RW = $clog2(RETRY_CYCLES + 1);

   typedef struct packed {
      logic [31:0]    cfg;
      logic [ST_W-1:0] stat;
      logic [ST_W-1:0] mask;
      logic           adapt;
      logic [2:0]     sync1;
      logic [2:0]     sync2;
      gdpc_oc_state_t oc_st;
      logic [7:0]     flt_cnt;
      logic [RW-1:0]  retry_cnt;
      logic [31:0]    prdata;
      logic           pready;
      logic           pslverr;
      logic           rd_stat;
      logic           irq;
      logic           ov_fault;
      logic           otw_out;
      logic           gain_fixed;
   } gdpc_state_t;

   gdpc_state_t s_q;
   gdpc_state_t s_d;

   logic       wr_done;
   logic       rd_done;
   logic       occlr;
   logic [1:0] resp;
   logic [7:0] flt_target;
   logic [ST_W-1:0] ev;

   always_comb
   begin
      s_d        = s_q;
      ev         = '0;
      occlr      = 1'b0;
      wr_done    = psel && penable && s_q.pready && pwrite;
      rd_done    = psel && penable && s_q.pready && !pwrite;
      resp       = s_q.cfg[RESP_LSB +: 2];
      flt_target = filt_cyc(s_q.cfg[FILT_LSB +: 2]);

      // Second stage alone reads the first
      s_d.sync1 = {overcurrent_raw, thermal_warning_raw, overvoltage_raw};
      s_d.sync2 = s_q.sync1;

      // One wait state; pready and read data come from flops
      s_d.pready  = psel && penable && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.rd_stat = 1'b0;
      if (psel && penable && !s_q.pready)
      begin
         s_d.prdata = 32'h0000_0000;
         if (paddr == OFS_CFG)
         begin
            s_d.prdata = s_q.cfg & CFG_WMASK;
         end
         else if (paddr == OFS_STAT)
         begin
            s_d.prdata  = 32'(s_q.stat);
            s_d.rd_stat = 1'b1;
         end
         else if (paddr == OFS_MASK)
         begin
            s_d.prdata = 32'(s_q.mask);
         end
         else if (paddr == OFS_CTRL)
         begin
            s_d.prdata = 32'(s_q.adapt);
         end
         else
         begin
            s_d.pslverr = 1'b1;
         end
      end

      if (wr_done)
      begin
         if (paddr == OFS_CFG)
         begin
            s_d.cfg = pwdata & CFG_WMASK;
         end
         else if (paddr == OFS_MASK)
         begin
            s_d.mask = pwdata[ST_W-1:0];
         end
         else if (paddr == OFS_CTRL)
         begin
            s_d.adapt = pwdata[CTL_ADAPT];
            occlr     = pwdata[CTL_OCCLR];
         end
      end

      // Overvoltage only flagged while enabled
      s_d.ov_fault = s_q.cfg[OVEN_BIT] && s_q.sync2[0];
      ev[ST_OV]    = s_d.ov_fault && !s_q.ov_fault;
      s_d.otw_out  = s_q.cfg[OTW_BIT] && s_q.sync2[1];
      ev[ST_OTW]   = s_d.otw_out && !s_q.otw_out;

      s_d.gain_fixed = !s_d.adapt;

      case (s_q.oc_st)
         GDPC_OC_IDLE:
         begin
            s_d.flt_cnt = 8'h00;
            if (s_q.sync2[2])
            begin
               s_d.oc_st = GDPC_OC_FILTER;
            end
         end
         GDPC_OC_FILTER:
         begin
            if (!s_q.sync2[2])
            begin
               s_d.oc_st = GDPC_OC_IDLE;
            end
            else if (s_q.flt_cnt >= flt_target - 8'h01)
            begin
               ev[ST_OCF]    = 1'b1;
               s_d.retry_cnt = '0;
               // Codes 2 and 3 are treated as latched
               if (resp == RESP_RETRY)
               begin
                  s_d.oc_st = GDPC_OC_RETRY;
               end
               else
               begin
                  s_d.oc_st = GDPC_OC_LATCHED;
               end
            end
            else
            begin
               s_d.flt_cnt = s_q.flt_cnt + 8'h01;
            end
         end
         GDPC_OC_LATCHED:
         begin
            if (occlr)
            begin
               s_d.oc_st = GDPC_OC_IDLE;
            end
         end
         GDPC_OC_RETRY:
         begin
            if (s_q.retry_cnt >= RW'(RETRY_CYCLES - 1))
            begin
               s_d.oc_st     = GDPC_OC_IDLE;
               ev[ST_RETRY]  = 1'b1;
            end
            else
            begin
               s_d.retry_cnt = s_q.retry_cnt + RW'(1);
            end
         end
         default:
         begin
            s_d.oc_st = GDPC_OC_IDLE;
         end
      endcase

      // Clear only what the read returned, so a new event is kept
      if (rd_done && s_q.rd_stat)
      begin
         s_d.stat = s_q.stat & ~s_q.prdata[ST_W-1:0];
      end
      s_d.stat = s_d.stat | ev;
      s_d.irq  = |(s_d.stat & s_d.mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q            <= '0;
         s_q.cfg        <= CFG_RESET;
         s_q.oc_st      <= GDPC_OC_IDLE;
         s_q.gain_fixed <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq     = s_q.irq;
   assign slew_rate_sel   = s_q.cfg[SLEW_LSB +: 2];
   assign slew_rate_valid = s_q.cfg[SLEW_LSB + 1];
   assign supply_overvoltage_level_sel = s_q.cfg[OVSEL_BIT];
   assign supply_overvoltage_fault     = s_q.ov_fault;
   assign thermal_warning_out          = s_q.otw_out;
   assign overcurrent_threshold_sel    = s_q.cfg[OCTHR_BIT];
   assign overcurrent_fault = s_q.oc_st[1];
   assign current_amp_gain_sel   = s_q.cfg[GAIN_LSB +: 2];
   assign current_amp_gain_fixed = s_q.gain_fixed;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence cfg_write;
      psel && penable && pready && pwrite && paddr == OFS_CFG;
   endsequence

   sequence oc_trip;
      $rose(overcurrent_fault);
   endsequence

   AST_CFG_WRITE: assert property (
      cfg_write |=> s_q.cfg == ($past(pwdata) & CFG_WMASK))
      else $error("Config write not stored");

   AST_RSV_ZERO: assert property (
      (s_q.cfg & ~CFG_WMASK) == 32'h0000_0000)
      else $error("Reserved config bit set");

   AST_SLEW: assert property (
      slew_rate_valid == (slew_rate_sel == SLEW_125 ||
                          slew_rate_sel == SLEW_200))
      else $error("Slew validity mismatch");

   AST_OV_OFF: assert property (
      !s_q.cfg[OVEN_BIT] |=> !supply_overvoltage_fault)
      else $error("Overvoltage flagged while disabled");

   AST_OTW_OFF: assert property (
      !s_q.cfg[OTW_BIT] |=> !thermal_warning_out)
      else $error("Thermal warning reported while off");

   AST_OC_LATCH: assert property (
      oc_trip ##0 ($past(resp) != RESP_RETRY) |->
         s_q.oc_st == GDPC_OC_LATCHED)
      else $error("Overcurrent did not latch");

   AST_OC_RETRY: assert property (
      s_q.oc_st == GDPC_OC_RETRY |->
         s_q.retry_cnt < RW'(RETRY_CYCLES))
      else $error("Retry count overran");

   AST_OC_FILTER: assert property (
      oc_trip |-> $past(s_q.flt_cnt) ==
         filt_cyc($past(s_q.cfg[FILT_LSB +: 2])) - 8'h01)
      else $error("Overcurrent filter length wrong");

   AST_GAIN: assert property (
      current_amp_gain_fixed == !s_q.adapt)
      else $error("Fixed gain flag wrong");

   AST_IRQ: assert property (
      ##1 irq == |(s_q.stat & s_q.mask))
      else $error("Interrupt does not follow status");

   AST_PREADY: assert property (
      psel && penable && !pready |=> pready)
      else $error("Missing ready");

   sequence stat_read;
      psel && penable && pready && !pwrite && paddr == OFS_STAT;
   endsequence

   // A bit raised in the same cycle must survive, so those cycles are left out
   AST_STAT_CLEAR: assert property (
      stat_read ##0 (ev == '0) |=>
         (s_q.stat & $past(prdata[ST_W-1:0])) == '0)
      else $error("Status read did not clear");

   AST_OC_RETRY_END: assert property (
      s_q.oc_st == GDPC_OC_RETRY &&
         s_q.retry_cnt == RW'(RETRY_CYCLES - 1) |=> !overcurrent_fault)
      else $error("Retry did not end on time");

endmodule
`default_nettype wire

// >>> tb/gdpc_top_tb.sv
// Self-checking bench for the gate driver protection configuration block.
// Assumes the design answers APB with one wait state; no partner model.
`default_nettype none
`define CHK(a, b) \
   begin \
      n_compared++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("BAD %0t %h %h", $time, (a), (b)); \
      end \
   end
module gdpc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gdpc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, ov, otw, oc, irq;
   logic [1:0]  slew, gain;
   logic        slew_v, ov_sel, ov_flt, otw_out, oc_thr, oc_flt, g_fix;
   int          n_fail, n_compared, k;
   // Cases incl. all ones and reserved bits only: value written, value read back
   logic [31:0] rows [6][2] = '{
      '{32'hffff_ffff, 32'h8c0d_3703}, '{32'h0800_0400, 32'h0800_0400},
      '{32'h0c08_0001, 32'h0c08_0001}, '{32'h7372_c8fc, 32'h0000_0000},
      '{32'h0400_0000, 32'h0400_0000}, '{32'h0000_0000, 32'h0000_0000}};
   gdpc_top #(.RETRY_CYCLES(50)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .overvoltage_raw(ov),
      .thermal_warning_raw(otw), .overcurrent_raw(oc), .irq(irq),
      .slew_rate_sel(slew), .slew_rate_valid(slew_v),
      .supply_overvoltage_level_sel(ov_sel),
      .supply_overvoltage_fault(ov_flt), .thermal_warning_out(otw_out),
      .overcurrent_threshold_sel(oc_thr), .overcurrent_fault(oc_flt),
      .current_amp_gain_sel(gain), .current_amp_gain_fixed(g_fix));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      tick(20000);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      ov = 1'b0;
      otw = 1'b0;
      oc = 1'b0;
      n_fail = 0;
      n_compared = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CFG, 32'h0);
      `CHK(rd, CFG_RESET)
      `CHK(g_fix, 1'b1)
      foreach (rows[i])
      begin
         apb(1'b1, OFS_CFG, rows[i][0]);
         apb(1'b0, OFS_CFG, 32'h0);
         `CHK(rd, rows[i][1])
         `CHK({slew, slew_v}, {rows[i][1][27:26], rows[i][1][27]})
         `CHK(ov_sel, rows[i][1][19])
         `CHK(oc_thr, rows[i][1][10])
         `CHK(gain, rows[i][1][1:0])
      end
      apb(1'b1, OFS_CTRL, 32'h1);
      tick(2);
      `CHK(g_fix, 1'b0)
      apb(1'b0, 8'h10, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // Events gated off must leave no trace
      apb(1'b1, OFS_MASK, 32'h3);
      ov <= 1'b1;
      otw <= 1'b1;
      tick(8);
      `CHK({ov_flt, otw_out, irq}, 3'b000)
      apb(1'b1, OFS_CFG, 32'h0005_0000);
      tick(6);
      `CHK({ov_flt, otw_out, irq}, 3'b111)
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[1:0], 2'b11)
      tick(2);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      ov <= 1'b0;
      otw <= 1'b0;
      // Latched response at shortest and longest filter
      for (int c = 0; c < 4; c += 3)
      begin
         apb(1'b1, OFS_CFG, 32'(c) << FILT_LSB);
         @(posedge pclk);
         oc <= 1'b1;
         for (k = 0; k < 200 && oc_flt !== 1'b1; k++) tick(1);
         `CHK((k - FILT_NS[c] / 10) inside {[3:5]}, 1'b1)
         @(posedge pclk);
         oc <= 1'b0;
         tick(80);
         `CHK(oc_flt, 1'b1)
         apb(1'b1, OFS_CTRL, 32'h2);
         tick(3);
         `CHK(oc_flt, 1'b0)
      end
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[3:0], 4'b0100)
      // Automatic retry ends the fault by itself
      apb(1'b1, OFS_CFG, 32'h0000_0100);
      oc <= 1'b1;
      tick(30);
      @(posedge pclk);
      oc <= 1'b0;
      `CHK(oc_flt, 1'b1)
      tick(40);
      `CHK(oc_flt, 1'b1)
      tick(20);
      `CHK(oc_flt, 1'b0)
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[3:2], 2'b11)
      // Reset in mid-run must bring config and gain flag back
      apb(1'b1, OFS_CFG, 32'hffff_ffff);
      apb(1'b1, OFS_CTRL, 32'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CFG, 32'h0);
      `CHK(rd, CFG_RESET)
      `CHK(g_fix, 1'b1)
      wrap_up();
   end
endmodule
`default_nettype wire
